// ==== verilog/lin_wake_map.svh ====
// How it works
// R1: Sleep/Stop accept bus, local, mode-select wakes.
// R2: Bus or local wake enters Stand-By.
// R3: Bus wake needs fall then long dominant.
// R4: Bus wake takes effect on next rise.
// R5: Long low on local input wakes device.
// R6: Short local low pulse is ignored.
// R7: Stand-By shows wake source on data pins.
// R8: Long mode-select high goes straight to Normal.
// R9: Mode-select wake gives no source indication.
// R10: Undriven mode-select reads as low.
// R11: Power-up starts in Stand-By.
// R12: Power-up shows receive high, transmit low.
// R13: Driver overheat disables transmitter, keeps receiver.
// R14: Driver cools, transmitter enabled again.
// R15: Driver overheat never changes the mode.
// R16: Regulator overheat switches output off, then on.
// R17: Bus wake: rx low tx high; local: both low.
// R18: Local wake filter between 30 and 150 us.
// R19: Mode filter between 50 and 150 us.
// R20: Source indication only in Stand-By.
// R21: Filter counters restart when input drops early.
`ifndef LIN_WAKE_MAP_SVH
`define LIN_WAKE_MAP_SVH

`define CLK_FREQ_HZ 125000000
`define HZ_PER_MHZ 1000000
`define TICK_CYCLES (`CLK_FREQ_HZ / `HZ_PER_MHZ)
`define LOCAL_WAKE_FILTER_US 30
`define MODE_CHANGE_FILTER_US 50
`define BUS_WAKE_FILTER_US 30
`define FILTER_CNT_W 8

`endif

// ==== verilog/lin_wake_pkg.sv ====
package lin_wake_pkg;
  typedef enum logic [1:0] {MODE_STANDBY, MODE_NORMAL, MODE_STOP, MODE_SLEEP} op_mode_t;
  typedef enum logic [1:0] {SRC_POWER, SRC_BUS, SRC_LOCAL, SRC_NONE} wake_src_t;
endpackage

// ==== verilog/pin_sync.sv ====
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_reg;

  initial begin
    if (WIDTH < 1) $error("pin_sync: WIDTH must be at least 1");
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= '0;
      q <= '0;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule
`default_nettype wire

// ==== verilog/duration_filter.sv ====
`timescale 1ns/100ps
`default_nettype none
module duration_filter #(
  parameter int CNT_W = 8,
  parameter int LIMIT_TICKS = 30
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic tick,
  input wire logic enable,
  input wire logic level,
  output logic qualified
);
  // The level must outlast LIMIT_TICKS whole ticks, so one extra tick is required.
  localparam logic [CNT_W-1:0] TARGET = CNT_W'(LIMIT_TICKS + 1);
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  wire active = enable && level;

  initial begin
    if (LIMIT_TICKS < 1 || LIMIT_TICKS + 1 >= (1 << CNT_W)) begin
      $error("duration_filter: LIMIT_TICKS does not fit CNT_W");
    end
  end

  assign cnt_next = !active ? '0 : // R21
    ((tick && cnt_reg != TARGET) ? cnt_reg + 1'b1 : cnt_reg);
  assign qualified = active && (cnt_reg == TARGET); // R6

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) cnt_reg <= '0;
    else cnt_reg <= cnt_next;
  end

  a_filter_restart: assert property (@(posedge clk) disable iff (!rst_n) // R21
    !active |=> cnt_reg == '0)
    else $error("filter counter not cleared after level dropped");

  a_filter_no_early: assert property (@(posedge clk) disable iff (!rst_n) // R6
    (active && cnt_reg < TARGET && !tick) |=> !qualified)
    else $error("filter qualified before the filter time");
endmodule
`default_nettype wire

// ==== verilog/lin_wake_ctrl.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "lin_wake_map.svh"
module lin_wake_ctrl #(
  parameter int TICK_CYCLES = `TICK_CYCLES,
  parameter int LOCAL_FILTER_US = `LOCAL_WAKE_FILTER_US,
  parameter int MODE_FILTER_US = `MODE_CHANGE_FILTER_US,
  parameter int BUS_FILTER_US = `BUS_WAKE_FILTER_US
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic bus_line,
  input wire logic local_wake_input,
  input wire logic mode_select,
  input wire logic bus_drv_overtemp,
  input wire logic reg_overtemp,
  input wire logic go_stop,
  input wire logic go_sleep,
  output lin_wake_pkg::op_mode_t op_mode,
  output logic bus_drv_enable,
  output logic bus_rx_enable,
  output logic regulator_enable,
  output logic rxd_out,
  output logic rxd_oe,
  output logic txd_out,
  output logic txd_oe
);
  initial begin
    if (TICK_CYCLES < 1) $error("lin_wake_ctrl: TICK_CYCLES must be positive");
    if (LOCAL_FILTER_US < 30 || LOCAL_FILTER_US > 150) begin
      $error("lin_wake_ctrl: local wake filter out of range"); // R18
    end
    if (MODE_FILTER_US < 50 || MODE_FILTER_US > 150) begin
      $error("lin_wake_ctrl: mode change filter out of range"); // R19
    end
  end

  // Reset is asserted at once and released through two flip-flops.
  logic rst_meta_reg;
  logic rst_n;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_reg <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n <= rst_meta_reg;
    end
  end

  // Pin inputs pass two flip-flops. Bus and local wake pass inverted, so the
  // synchroniser's reset value reads as their idle high level and no false
  // falling edge follows reset. A floating mode-select is held low by the pad
  // pull-down and reads low from reset on, so nothing starts a mode change.
  logic [4:0] pins_s;
  pin_sync #(.WIDTH(5)) u_pin_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d({~bus_line, ~local_wake_input, mode_select, bus_drv_overtemp, reg_overtemp}),
    .q(pins_s)
  );
  wire bus_s = !pins_s[4];
  wire wake_s = !pins_s[3];
  wire mode_sel_high = (pins_s[2] == 1'b1); // R10
  wire drv_ot_s = pins_s[1];
  wire reg_ot_s = pins_s[0];

  // One-microsecond timebase for the duration filters.
  localparam int TICK_W = $clog2(TICK_CYCLES + 1);
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);
  logic [TICK_W-1:0] div_reg;
  wire tick = (div_reg == TICK_LAST); // R21
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) div_reg <= '0;
    else div_reg <= tick ? '0 : div_reg + 1'b1;
  end

  lin_wake_pkg::op_mode_t mode_reg;
  lin_wake_pkg::op_mode_t mode_next;
  lin_wake_pkg::wake_src_t src_reg;
  lin_wake_pkg::wake_src_t src_next;

  wire low_power = (mode_reg == lin_wake_pkg::MODE_SLEEP) ||
    (mode_reg == lin_wake_pkg::MODE_STOP);
  wire standby = (mode_reg == lin_wake_pkg::MODE_STANDBY);
  wire normal = (mode_reg == lin_wake_pkg::MODE_NORMAL);

  // Edge tracking: a wake only counts a low level that began with a falling edge
  // seen while in a low-power mode.
  logic bus_prev_reg;
  logic wake_prev_reg;
  logic bus_edge_reg;
  logic wake_edge_reg;
  logic bus_armed_reg;
  wire bus_fall = bus_prev_reg && !bus_s;
  wire bus_rise = !bus_prev_reg && bus_s;
  wire wake_fall = wake_prev_reg && !wake_s;
  wire bus_edge_next = low_power && !bus_s && (bus_edge_reg || bus_fall); // R3
  wire wake_edge_next = low_power && !wake_s && (wake_edge_reg || wake_fall); // R5

  logic bus_q;
  logic local_q;
  logic mode_q;
  duration_filter #(.CNT_W(`FILTER_CNT_W), .LIMIT_TICKS(BUS_FILTER_US)) u_bus_filter (
    .clk(clk),
    .rst_n(rst_n),
    .tick(tick),
    .enable(low_power),
    .level(bus_edge_reg && !bus_s),
    .qualified(bus_q)
  );
  duration_filter #(.CNT_W(`FILTER_CNT_W), .LIMIT_TICKS(LOCAL_FILTER_US)) u_local_filter (
    .clk(clk),
    .rst_n(rst_n),
    .tick(tick),
    .enable(low_power),
    .level(wake_edge_reg && !wake_s),
    .qualified(local_q)
  );
  duration_filter #(.CNT_W(`FILTER_CNT_W), .LIMIT_TICKS(MODE_FILTER_US)) u_mode_filter (
    .clk(clk),
    .rst_n(rst_n),
    .tick(tick),
    .enable(low_power || standby),
    .level(mode_sel_high),
    .qualified(mode_q)
  );

  // A qualified bus wake waits for the bus to return recessive.
  wire bus_armed_next = low_power && (bus_armed_reg || bus_q); // R3
  wire bus_fire = low_power && bus_armed_reg && bus_rise; // R4
  wire local_fire = low_power && local_q; // R5

  // Mode-select wins over a simultaneous bus or local wake. The overtemperature
  // inputs are deliberately absent here.
  always_comb begin // R15
    mode_next = mode_reg;
    src_next = src_reg;
    case (mode_reg)
      lin_wake_pkg::MODE_SLEEP, lin_wake_pkg::MODE_STOP: begin // R1
        if (mode_q) begin
          mode_next = lin_wake_pkg::MODE_NORMAL; // R8
          src_next = lin_wake_pkg::SRC_NONE; // R9
        end else if (bus_fire) begin
          mode_next = lin_wake_pkg::MODE_STANDBY; // R2
          src_next = lin_wake_pkg::SRC_BUS;
        end else if (local_fire) begin
          mode_next = lin_wake_pkg::MODE_STANDBY; // R2
          src_next = lin_wake_pkg::SRC_LOCAL;
        end else if (mode_reg == lin_wake_pkg::MODE_STOP && go_sleep) begin
          mode_next = lin_wake_pkg::MODE_SLEEP;
        end
      end
      lin_wake_pkg::MODE_STANDBY: begin
        if (mode_q) mode_next = lin_wake_pkg::MODE_NORMAL;
      end
      lin_wake_pkg::MODE_NORMAL: begin
        if (go_stop) mode_next = lin_wake_pkg::MODE_STOP;
        else if (go_sleep) mode_next = lin_wake_pkg::MODE_SLEEP;
      end
      default: begin
        mode_next = lin_wake_pkg::MODE_STANDBY;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_reg <= lin_wake_pkg::MODE_STANDBY; // R11
      src_reg <= lin_wake_pkg::SRC_POWER; // R12
    end else begin
      mode_reg <= mode_next;
      src_reg <= src_next;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_prev_reg <= 1'b1;
      wake_prev_reg <= 1'b1;
      bus_edge_reg <= 1'b0;
      wake_edge_reg <= 1'b0;
      bus_armed_reg <= 1'b0;
    end else begin
      bus_prev_reg <= bus_s;
      wake_prev_reg <= wake_s;
      bus_edge_reg <= bus_edge_next;
      wake_edge_reg <= wake_edge_next;
      bus_armed_reg <= bus_armed_next;
    end
  end

  // Source indication is driven only in Stand-By and only for a known source.
  wire indicate = standby && (src_reg != lin_wake_pkg::SRC_NONE); // R20
  assign rxd_oe = indicate; // R7
  assign txd_oe = indicate; // R7
  assign rxd_out = indicate && (src_reg == lin_wake_pkg::SRC_POWER); // R17
  assign txd_out = indicate && (src_reg == lin_wake_pkg::SRC_BUS); // R17
  assign op_mode = mode_reg;
  assign bus_drv_enable = normal && !drv_ot_s; // R13 R14
  assign bus_rx_enable = normal; // R13
  assign regulator_enable = (mode_reg != lin_wake_pkg::MODE_SLEEP) && !reg_ot_s; // R16

  // Check-only counters of how many cycles the bus, local wake and mode-select inputs have stood at their active
  // level. They saturate rather than wrap, and let the filter-time assertions
  // below hold the filters to the configured durations independently.
  localparam int HOLD_W = 24;
  localparam logic [HOLD_W-1:0] HOLD_MAX = '1;
  localparam logic [HOLD_W-1:0] BUS_MIN = HOLD_W'(BUS_FILTER_US * TICK_CYCLES);
  localparam logic [HOLD_W-1:0] LOCAL_MIN = HOLD_W'(LOCAL_FILTER_US * TICK_CYCLES);
  localparam logic [HOLD_W-1:0] MODE_MIN = HOLD_W'(MODE_FILTER_US * TICK_CYCLES);
  logic [HOLD_W-1:0] bus_low_cnt_reg;
  logic [HOLD_W-1:0] wake_low_cnt_reg;
  logic [HOLD_W-1:0] mode_high_cnt_reg;
  wire logic [HOLD_W-1:0] bus_low_cnt_next = bus_s ? '0 :
    ((bus_low_cnt_reg == HOLD_MAX) ? HOLD_MAX : bus_low_cnt_reg + 1'b1);
  wire logic [HOLD_W-1:0] wake_low_cnt_next = wake_s ? '0 :
    ((wake_low_cnt_reg == HOLD_MAX) ? HOLD_MAX : wake_low_cnt_reg + 1'b1);
  wire logic [HOLD_W-1:0] mode_high_cnt_next = !mode_sel_high ? '0 :
    ((mode_high_cnt_reg == HOLD_MAX) ? HOLD_MAX : mode_high_cnt_reg + 1'b1);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_low_cnt_reg <= '0;
      wake_low_cnt_reg <= '0;
      mode_high_cnt_reg <= '0;
    end else begin
      bus_low_cnt_reg <= bus_low_cnt_next;
      wake_low_cnt_reg <= wake_low_cnt_next;
      mode_high_cnt_reg <= mode_high_cnt_next;
    end
  end

  sequence s_bus_armed_wait;
    low_power && bus_armed_reg && !mode_q;
  endsequence
  sequence s_bus_release;
    bus_rise;
  endsequence

  a_bus_wake_rise: assert property (@(posedge clk) disable iff (!rst_n) // R4
    (s_bus_armed_wait ##0 s_bus_release) |=>
      (mode_reg == lin_wake_pkg::MODE_STANDBY) && (src_reg == lin_wake_pkg::SRC_BUS))
    else $error("bus wake did not enter Stand-By on the rising edge");

  a_bus_wait_rise: assert property (@(posedge clk) disable iff (!rst_n) // R3
    (low_power && !bus_rise && !local_fire && !mode_q && !go_sleep) |=> $stable(mode_reg))
    else $error("mode left low power without a qualifying event");

  a_local_wake_entry: assert property (@(posedge clk) disable iff (!rst_n) // R5
    (low_power && local_q && !mode_q && !bus_fire) |=>
      (mode_reg == lin_wake_pkg::MODE_STANDBY) && (src_reg == lin_wake_pkg::SRC_LOCAL))
    else $error("local wake did not enter Stand-By");

  a_mode_select_direct: assert property (@(posedge clk) disable iff (!rst_n) // R8
    (low_power && mode_q) |=> normal && !rxd_oe && !txd_oe)
    else $error("mode-select did not go straight to Normal");

  a_source_encoding: assert property (@(posedge clk) disable iff (!rst_n) // R17
    (standby && src_reg == lin_wake_pkg::SRC_BUS) |-> rxd_oe && txd_oe && !rxd_out && txd_out)
    else $error("bus wake indication wrong");

  a_local_encoding: assert property (@(posedge clk) disable iff (!rst_n) // R17
    (standby && src_reg == lin_wake_pkg::SRC_LOCAL) |-> rxd_oe && !rxd_out && !txd_out)
    else $error("local wake indication wrong");

  a_powerup_indication: assert property (@(posedge clk) disable iff (!rst_n) // R12
    $rose(rst_n) |-> standby && rxd_oe && rxd_out && txd_oe && !txd_out)
    else $error("power-up indication wrong");

  a_quiet_outside: assert property (@(posedge clk) disable iff (!rst_n) // R20
    !standby |-> !rxd_oe && !txd_oe)
    else $error("data pins driven outside Stand-By");

  a_driver_overtemp: assert property (@(posedge clk) disable iff (!rst_n) // R13
    drv_ot_s |-> !bus_drv_enable && (bus_rx_enable == normal))
    else $error("driver not disabled during overtemperature");

  a_driver_resume: assert property (@(posedge clk) disable iff (!rst_n) // R14
    ($fell(drv_ot_s) && normal) |-> bus_drv_enable)
    else $error("driver not enabled after cooling");

  a_overtemp_no_mode: assert property (@(posedge clk) disable iff (!rst_n) // R15
    (normal && $changed(drv_ot_s) && !go_stop && !go_sleep) |=> normal)
    else $error("driver overtemperature changed the mode");

  a_regulator_overtemp: assert property (@(posedge clk) disable iff (!rst_n) // R16
    regulator_enable == (!reg_ot_s && mode_reg != lin_wake_pkg::MODE_SLEEP))
    else $error("regulator enable wrong");

  a_bus_filter_time: assert property (@(posedge clk) disable iff (!rst_n) // R3
    bus_q |-> bus_low_cnt_reg >= BUS_MIN)
    else $error("bus wake qualified before the filter time");

  a_local_filter_time: assert property (@(posedge clk) disable iff (!rst_n) // R18
    local_q |-> wake_low_cnt_reg >= LOCAL_MIN)
    else $error("local wake qualified before the filter time");

  a_mode_filter_time: assert property (@(posedge clk) disable iff (!rst_n) // R19
    mode_q |-> mode_high_cnt_reg >= MODE_MIN)
    else $error("mode-select qualified before the filter time");

  sequence s_low_power_no_rise;
    low_power && !bus_rise;
  endsequence

  a_bus_wake_gated: assert property (@(posedge clk) disable iff (!rst_n) // R4
    s_low_power_no_rise |=> !(standby && src_reg == lin_wake_pkg::SRC_BUS))
    else $error("bus wake entered Stand-By without a rising edge");

  a_standby_hold: assert property (@(posedge clk) disable iff (!rst_n) // R20
    (standby && !mode_q) |=> standby)
    else $error("Stand-By left without a mode-select request");

  a_regulator_sleep: assert property (@(posedge clk) disable iff (!rst_n) // R16
    (mode_reg == lin_wake_pkg::MODE_SLEEP) |-> !regulator_enable)
    else $error("regulator left on in Sleep");
endmodule
`default_nettype wire

// ==== sim/lin_host_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module lin_host_model (
  input wire logic clk,
  output logic bus_line,
  output logic local_wake_input,
  output logic mode_select
);
  // Idle levels follow the pad pulls: bus recessive, wake pulled up, mode pulled down.
  initial begin
    bus_line = 1'b1;
    local_wake_input = 1'b1;
    mode_select = 1'b0;
  end

  // Pin 0 is the bus, 1 the local wake, 2 mode-select; on puts the active level.
  task automatic set_pin(input int pin, input logic on);
    @(posedge clk);
    #1;
    case (pin)
      0: bus_line = ~on;
      1: local_wake_input = ~on;
      default: mode_select = on;
    endcase
  endtask
endmodule
`default_nettype wire

// ==== sim/tb_lin_wake_ctrl.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb_lin_wake_ctrl;
  localparam int TICK = 2;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic bus_drv_overtemp = 1'b0;
  logic reg_overtemp = 1'b0;
  logic go_stop = 1'b0;
  logic go_sleep = 1'b0;
  wire logic bus_line;
  wire logic local_wake_input;
  wire logic mode_select;
  lin_wake_pkg::op_mode_t op_mode;
  logic bus_drv_enable, bus_rx_enable, regulator_enable;
  logic rxd_out, rxd_oe, txd_out, txd_oe;
  wire logic [3:0] mode4 = {2'b00, op_mode};
  wire logic [3:0] ind = {rxd_oe, rxd_out, txd_oe, txd_out};
  wire logic [3:0] ena = {1'b0, bus_drv_enable, bus_rx_enable, regulator_enable};
  int n_mismatch = 0;
  int cmp_count = 0;

  always #4 clk = ~clk;

  lin_host_model i_host (.clk(clk), .bus_line(bus_line), .local_wake_input(local_wake_input),
    .mode_select(mode_select));

  lin_wake_ctrl #(.TICK_CYCLES(TICK)) i_dut (.clk(clk), .reset_n(reset_n), .bus_line(bus_line),
    .local_wake_input(local_wake_input), .mode_select(mode_select),
    .bus_drv_overtemp(bus_drv_overtemp), .reg_overtemp(reg_overtemp), .go_stop(go_stop),
    .go_sleep(go_sleep), .op_mode(op_mode), .bus_drv_enable(bus_drv_enable),
    .bus_rx_enable(bus_rx_enable), .regulator_enable(regulator_enable), .rxd_out(rxd_out),
    .rxd_oe(rxd_oe), .txd_out(txd_out), .txd_oe(txd_oe));

  task automatic check(input string name, input logic [3:0] seen, input logic [3:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wait_mode(input lin_wake_pkg::op_mode_t m, input int limit);
    int i;
    i = 0;
    while (op_mode !== m && i < limit) begin
      cycles(1);
      i++;
    end
  endtask

  // Holds one pin at its active level for n + 1 cycles, then lets it go idle.
  task automatic hold_pin(input int pin, input int n);
    i_host.set_pin(pin, 1'b1);
    cycles(n);
    i_host.set_pin(pin, 1'b0);
    cycles(4);
  endtask

  task automatic request(input logic stop_not_sleep);
    @(posedge clk);
    #1;
    go_stop = stop_not_sleep;
    go_sleep = ~stop_not_sleep;
    cycles(1);
    go_stop = 1'b0;
    go_sleep = 1'b0;
  endtask

  task automatic go_normal;
    hold_pin(2, 150);
    wait_mode(lin_wake_pkg::MODE_NORMAL, 20);
    check("normal mode", mode4, {2'b00, lin_wake_pkg::MODE_NORMAL});
    check("normal oe", ind & 4'ha, 4'h0);
  endtask

  task automatic t_powerup;
    check("reset mode", mode4, {2'b00, lin_wake_pkg::MODE_STANDBY});
    check("power indication", ind, 4'he);
    $display("test powerup done");
  endtask

  task automatic t_overtemp;
    go_normal();
    bus_drv_overtemp = 1'b1;
    cycles(5);
    check("driver hot enables", ena, 4'h3);
    check("driver hot mode", mode4, {2'b00, lin_wake_pkg::MODE_NORMAL});
    bus_drv_overtemp = 1'b0;
    cycles(5);
    check("driver cool enables", ena, 4'h7);
    reg_overtemp = 1'b1;
    cycles(5);
    check("regulator hot", ena, 4'h6);
    reg_overtemp = 1'b0;
    cycles(5);
    check("regulator cool", ena, 4'h7);
    $display("test overtemp done");
  endtask

  task automatic t_local_wake;
    request(1'b0);
    wait_mode(lin_wake_pkg::MODE_SLEEP, 10);
    check("sleep entered", mode4, {2'b00, lin_wake_pkg::MODE_SLEEP});
    check("sleep enables", ena, 4'h0);
    hold_pin(1, 40);
    hold_pin(2, 60);
    hold_pin(2, 60);
    check("short pulses ignored", mode4, {2'b00, lin_wake_pkg::MODE_SLEEP});
    hold_pin(1, 120);
    wait_mode(lin_wake_pkg::MODE_STANDBY, 10);
    check("local wake mode", mode4, {2'b00, lin_wake_pkg::MODE_STANDBY});
    check("local indication", ind, 4'ha);
    $display("test local wake done");
  endtask

  task automatic t_bus_wake;
    go_normal();
    request(1'b1);
    wait_mode(lin_wake_pkg::MODE_STOP, 10);
    check("stop entered", mode4, {2'b00, lin_wake_pkg::MODE_STOP});
    check("stop enables", ena, 4'h1);
    i_host.set_pin(0, 1'b1);
    cycles(200);
    check("wake waits for rise", mode4, {2'b00, lin_wake_pkg::MODE_STOP});
    i_host.set_pin(0, 1'b0);
    wait_mode(lin_wake_pkg::MODE_STANDBY, 10);
    check("bus wake mode", mode4, {2'b00, lin_wake_pkg::MODE_STANDBY});
    check("bus indication", ind, 4'hb);
    hold_pin(1, 120);
    check("no wake in standby", ind, 4'hb);
    check("standby kept", mode4, {2'b00, lin_wake_pkg::MODE_STANDBY});
    go_normal();
    request(1'b0);
    wait_mode(lin_wake_pkg::MODE_SLEEP, 10);
    go_normal();
    $display("test bus wake done");
  endtask

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    cycles(10);
    reset_n = 1'b1;
    cycles(4);
    t_powerup();
    t_overtemp();
    t_local_wake();
    t_bus_wake();
    end_sim();
  end

  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    $display("ERROR watchdog expected done seen hang");
    end_sim();
  end
endmodule
`default_nettype wire
